// ===== include/flash_bank_pkg.sv
// Purpose: Shared constants and types for the flash driver register bank
// Assumes: Two-wire target port sampled by a 100 MHz system clock
// Notes:   Offsets are register indices carried in the index byte

package flash_bank_pkg;

    // Own seven-bit target address
    localparam logic [6:0] DEV_ADDR         = 7'h63;

    // Register indices
    localparam logic [7:0] OFS_ENABLE       = 8'h01;
    localparam logic [7:0] OFS_VMON_CFG     = 8'h02;
    localparam logic [7:0] OFS_FLASH_ONE    = 8'h03;
    localparam logic [7:0] OFS_FLASH_TWO    = 8'h04;
    localparam logic [7:0] OFS_TORCH_ONE    = 8'h05;
    localparam logic [7:0] OFS_TORCH_TWO    = 8'h06;
    localparam logic [7:0] OFS_BOOST        = 8'h07;
    localparam logic [7:0] OFS_TIMING       = 8'h08;
    localparam logic [7:0] OFS_THERMISTOR   = 8'h09;
    localparam logic [7:0] OFS_FLAGS_ONE    = 8'h0A;
    localparam logic [7:0] OFS_FLAGS_TWO    = 8'h0B;
    localparam logic [7:0] OFS_PART_ID      = 8'h0C;
    localparam logic [7:0] OFS_PREV_FLASH   = 8'h0D;

    // Writable registers occupy indices 0x01 to 0x09
    localparam int         NUM_RW           = 9;
    localparam logic [NUM_RW-1:0][7:0] RW_RESET = {
        8'h08, 8'h1A, 8'h09, 8'h3F, 8'hBF, 8'h3F, 8'hBF, 8'h01, 8'h80};
    localparam logic [7:0] FLAGS_RESET      = 8'h00;
    localparam logic [7:0] PREV_FLASH_RESET = 8'h00;
    // Identification value, arbitrary
    localparam logic [7:0] PART_ID_DEFAULT  = 8'h5A;

    // Field positions
    localparam int         EN_STROBE_TYPE   = 6;
    localparam int         EN_MODE_LSB      = 2;
    localparam int         VMON_LEVEL_LSB   = 3;
    localparam int         VMON_SEL_LSB     = 0;
    localparam int         LED_CODE_LSB     = 0;

    // Operating modes
    localparam logic [1:0] MODE_STANDBY     = 2'h0;
    localparam logic [1:0] MODE_INFRARED    = 2'h1;
    localparam logic [1:0] MODE_TORCH       = 2'h2;
    localparam logic [1:0] MODE_FLASH       = 2'h3;

    // Monitor selections and threshold scale (code 0 is 2.9 V, 0.1 V a step)
    localparam logic [1:0] VMON_DISABLED    = 2'h0;
    localparam logic [1:0] VMON_STOP_HOLD   = 2'h1;
    localparam logic [1:0] VMON_DOWN_ONLY   = 2'h2;
    localparam logic [1:0] VMON_UP_DOWN     = 2'h3;
    localparam int         VMON_BASE_MV     = 2900;
    localparam int         VMON_STEP_MV     = 100;

    // Flash current scale in microamps: code times step plus base
    localparam int         LED_STEP_UA      = 11725;
    localparam int         LED_BASE_UA      = 10900;

    // Bit counts within one byte slot
    localparam logic [3:0] BYTE_BITS        = 4'h8;
    localparam logic [3:0] ACK_BIT          = 4'h9;

    // Transfer states
    typedef enum logic [3:0] {
        ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_INDEX, ST_INDEX_ACK,
        ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RACK, ST_IGNORE
    } xfer_st_t;

    // Pin front end state
    typedef struct packed {
        logic scl_meta;
        logic sda_meta;
        logic scl_sync;
        logic sda_sync;
        logic scl_prev;
        logic sda_prev;
        logic start_ev;
        logic stop_ev;
        logic rise_ev;
        logic fall_ev;
        logic sda_level;
    } front_state_t;

    // Register bank state
    typedef struct packed {
        xfer_st_t                st;
        logic [3:0]              bitcnt;
        logic [7:0]              shift;
        logic                    rd;
        logic                    mack;
        logic [7:0]              idx;
        logic                    sda_oe;
        logic [NUM_RW-1:0][7:0]  rw;
        logic [7:0]              flags_one;
        logic [7:0]              flags_two;
        logic [15:0]             fault_meta;
        logic [15:0]             fault_sync;
        logic [7:0]              prev_meta;
        logic [7:0]              prev_sync;
        logic                    locked;
        logic                    seen_one;
        logic                    seen_two;
        logic [1:0]              vmon_sel;
        logic [1:0]              op_mode;
        logic                    strobe_edge;
        logic [2:0]              vmon_level;
        logic [6:0]              led_one_code;
        logic                    busy;
    } bank_state_t;

endpackage

// ===== hw/serial_pin_front.sv
// Purpose: Synchronise the serial clock and data pins and find bus events
// Assumes: System clock far faster than the serial clock
// Notes:   Events are one-cycle pulses, all registered

`timescale 1ns/1ps

module serial_pin_front
    import flash_bank_pkg::*;
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic nrst,
    // Pins
    input  wire logic scl_pin,
    input  wire logic sda_pin,
    // Events
    output logic      start_ev,
    output logic      stop_ev,
    output logic      rise_ev,
    output logic      fall_ev,
    output logic      sda_level
);

    front_state_t q;      // Current state
    front_state_t next_q; // Next state

    // Two-stage sync, then edge and condition detection on synced levels
    always_comb begin
        next_q          = q;
        next_q.scl_meta = scl_pin;
        next_q.sda_meta = sda_pin;
        next_q.scl_sync = q.scl_meta;
        next_q.sda_sync = q.sda_meta;
        next_q.scl_prev = q.scl_sync;
        next_q.sda_prev = q.sda_sync;
        // Data falling while clock high marks a start
        next_q.start_ev = q.scl_sync && q.scl_prev && q.sda_prev && !q.sda_sync;
        // Data rising while clock high marks a stop
        next_q.stop_ev  = q.scl_sync && q.scl_prev && !q.sda_prev && q.sda_sync;
        next_q.rise_ev  = q.scl_sync && !q.scl_prev;
        next_q.fall_ev  = !q.scl_sync && q.scl_prev;
        next_q.sda_level = q.sda_sync;
    end

    // State register, idle bus is high
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            q <= '{scl_meta: 1'b1, sda_meta: 1'b1, scl_sync: 1'b1, sda_sync: 1'b1,
                   scl_prev: 1'b1, sda_prev: 1'b1, sda_level: 1'b1, default: 1'b0};
        end else begin
            q <= next_q;
        end
    end

    assign start_ev  = q.start_ev;
    assign stop_ev   = q.stop_ev;
    assign rise_ev   = q.rise_ev;
    assign fall_ev   = q.fall_ev;
    assign sda_level = q.sda_level;

endmodule

// ===== hw/flash_register_bank.sv
// Purpose: Two-wire target port and register bank of a dual flash LED driver
// Assumes: Pins and fault inputs are asynchronous; host is the bus master
// Notes:   Summary of operation below
//
// Summary of operation
// - Data changes only while clock low
// - Detect start and stop conditions
// - Bus busy from start until stop
// - Repeated start restarts address reception
// - Bytes are eight bits, MSB first
// - Acknowledge own address and every byte received after it on ninth pulse
// - No acknowledge after returned read bytes
// - Answer only address 0x63
// - Direction bit zero writes, one reads
// - Second byte index, third byte data
// - Thirteen registers with power-on values
// - Mode field selects standby, infrared, torch, flash
// - Strobe type; no edge mode in infrared
// - Fault sets flag, standby, locks until read
// - Monitor mode frozen while not in standby

`timescale 1ns/1ps

module flash_register_bank
    import flash_bank_pkg::*;
#(
    parameter logic [7:0] PART_ID = PART_ID_DEFAULT // Arbitrary identification value
)
(
    // Clock and reset
    input  wire logic       CLK_SYS,
    input  wire logic       NRST,
    // Serial bus pins
    input  wire logic       SCL,
    input  wire logic       SDA_IN,
    output logic            SDA_OUT,
    output logic            SDA_OE,
    // Fault events and flash history from the power stage
    input  wire logic [7:0] FAULT_ONE_EVENT,
    input  wire logic [7:0] FAULT_TWO_EVENT,
    input  wire logic [7:0] PREV_FLASH_LEVEL,
    // Controls to the power stage
    output logic [1:0]      OP_MODE,
    output logic            STROBE_EDGE,
    output logic [2:0]      VMON_LEVEL,
    output logic [1:0]      VMON_SELECT,
    output logic [6:0]      LED_ONE_FLASH_CODE,
    // Status
    output logic            RESTART_LOCKED,
    output logic            BUS_BUSY
);

    bank_state_t q;        // Current state
    bank_state_t next_q;   // Next state
    logic        start_ev; // Start or repeated start seen
    logic        stop_ev;  // Stop seen
    logic        rise_ev;  // Serial clock rose
    logic        fall_ev;  // Serial clock fell
    logic        sda_lvl;  // Synced data level

    // Pin synchronisers and event detection
    serial_pin_front u_front (
        .clk       (CLK_SYS),
        .nrst      (NRST),
        .scl_pin   (SCL),
        .sda_pin   (SDA_IN),
        .start_ev  (start_ev),
        .stop_ev   (stop_ev),
        .rise_ev   (rise_ev),
        .fall_ev   (fall_ev),
        .sda_level (sda_lvl)
    );

    // Index falls on a writable register
    function automatic logic is_rw(input logic [7:0] idx);
        return (idx >= OFS_ENABLE) && (idx <= OFS_THERMISTOR);
    endfunction

    // Slot of a writable register in the array
    function automatic logic [3:0] rw_slot(input logic [7:0] idx);
        logic [7:0] d;
        d = idx - OFS_ENABLE;
        return d[3:0];
    endfunction

    // Read value of any register, unmapped reads as zero
    function automatic logic [7:0] read_reg(input bank_state_t s, input logic [7:0] idx);
        logic [7:0] v;
        v = 8'h00;
        if (is_rw(idx)) begin
            v = s.rw[rw_slot(idx)];
        end else begin
            case (idx)
                OFS_FLAGS_ONE:  v = s.flags_one;
                OFS_FLAGS_TWO:  v = s.flags_two;
                OFS_PART_ID:    v = PART_ID;
                OFS_PREV_FLASH: v = s.prev_sync;
                default:        v = 8'h00;
            endcase
        end
        return v;
    endfunction

    // Transfer engine, register bank and fault handling
    always_comb begin
        logic       load;   // Fetch a read byte this cycle
        logic [7:0] rdata;  // Fetched byte
        logic [7:0] wdata;  // Byte to store
        logic       clr1;   // First flag register read
        logic       clr2;   // Second flag register read
        logic       fault;  // Any synced fault event
        load   = 1'b0;
        rdata  = read_reg(q, q.idx);
        wdata  = q.shift;
        clr1   = 1'b0;
        clr2   = 1'b0;
        fault  = |q.fault_sync;
        next_q = q;
        // Second stage only reads the first
        next_q.fault_meta = {FAULT_TWO_EVENT, FAULT_ONE_EVENT};
        next_q.fault_sync = q.fault_meta;
        next_q.prev_meta  = PREV_FLASH_LEVEL;
        next_q.prev_sync  = q.prev_meta;

        if (start_ev) begin
            // First and repeated start behave alike
            next_q.st     = ST_ADDR;
            next_q.bitcnt = 4'h0;
            next_q.sda_oe = 1'b0;
        end else if (stop_ev) begin
            // Bus free again
            next_q.st     = ST_IDLE;
            next_q.sda_oe = 1'b0;
        end else begin
            case (q.st)
                // Receive a byte, MSB first, sampled on clock rise
                ST_ADDR, ST_INDEX, ST_WDATA: begin
                    if (rise_ev && q.bitcnt < BYTE_BITS) begin
                        next_q.shift  = {q.shift[6:0], sda_lvl};
                        next_q.bitcnt = q.bitcnt + 4'h1;
                    end else if (fall_ev && q.bitcnt == BYTE_BITS) begin
                        // Drive acknowledge only after the clock is low
                        next_q.bitcnt = 4'h0;
                        next_q.sda_oe = 1'b1;
                        if (q.st == ST_ADDR) begin
                            if (q.shift[7:1] == DEV_ADDR) begin
                                next_q.rd = q.shift[0];
                                next_q.st = ST_ADDR_ACK;
                            end else begin
                                // Stay off the line until the next start
                                next_q.sda_oe = 1'b0;
                                next_q.st     = ST_IGNORE;
                            end
                        end else if (q.st == ST_INDEX) begin
                            next_q.idx = q.shift;
                            next_q.st  = ST_INDEX_ACK;
                        end else begin
                            // Data byte lands in the indexed register
                            if (is_rw(q.idx)) begin
                                if (q.idx == OFS_ENABLE && q.locked) begin
                                    // Restart refused while fault flags unread
                                    wdata[EN_MODE_LSB +: 2] = MODE_STANDBY;
                                end
                                next_q.rw[rw_slot(q.idx)] = wdata;
                            end
                            next_q.st = ST_WDATA_ACK;
                        end
                    end
                end
                // Acknowledge pulse, release on its falling edge
                ST_ADDR_ACK, ST_INDEX_ACK, ST_WDATA_ACK: begin
                    if (rise_ev) begin
                        next_q.bitcnt = ACK_BIT;
                    end else if (fall_ev && q.bitcnt == ACK_BIT) begin
                        next_q.bitcnt = 4'h0;
                        next_q.sda_oe = 1'b0;
                        if (q.st == ST_ADDR_ACK && q.rd) begin
                            // Return the register named by the last index
                            load      = 1'b1;
                            next_q.st = ST_RDATA;
                        end else if (q.st == ST_ADDR_ACK) begin
                            next_q.st = ST_INDEX;
                        end else begin
                            next_q.st = ST_WDATA;
                        end
                    end
                end
                // Send a byte, next bit set up on each clock fall
                ST_RDATA: begin
                    if (rise_ev) begin
                        next_q.bitcnt = q.bitcnt + 4'h1;
                    end else if (fall_ev && q.bitcnt == BYTE_BITS) begin
                        // Line left released for the master's answer
                        next_q.sda_oe = 1'b0;
                        next_q.bitcnt = 4'h0;
                        next_q.st     = ST_RACK;
                    end else if (fall_ev) begin
                        next_q.shift  = {q.shift[6:0], 1'b0};
                        next_q.sda_oe = !q.shift[6];
                    end
                end
                // Master answers; low asks for another byte
                ST_RACK: begin
                    if (rise_ev) begin
                        next_q.bitcnt = ACK_BIT;
                        next_q.mack   = !sda_lvl;
                    end else if (fall_ev && q.bitcnt == ACK_BIT) begin
                        next_q.bitcnt = 4'h0;
                        if (q.mack) begin
                            load      = 1'b1;
                            next_q.st = ST_RDATA;
                        end else begin
                            next_q.st = ST_IGNORE;
                        end
                    end
                end
                // Wait for start or stop
                ST_IDLE, ST_IGNORE: begin
                    next_q.st = q.st;
                end
                default: begin
                    next_q.st     = ST_IDLE;
                    next_q.sda_oe = 1'b0;
                end
            endcase
        end

        // First read bit goes out as the clock falls
        if (load) begin
            next_q.shift  = rdata;
            next_q.sda_oe = !rdata[7];
            clr1          = (q.idx == OFS_FLAGS_ONE);
            clr2          = (q.idx == OFS_FLAGS_TWO);
        end

        // Flags clear on read, a new event in the same cycle wins
        next_q.flags_one = (q.flags_one & {8{!clr1}}) | q.fault_sync[7:0];
        next_q.flags_two = (q.flags_two & {8{!clr2}}) | q.fault_sync[15:8];
        next_q.seen_one  = q.seen_one || clr1;
        next_q.seen_two  = q.seen_two || clr2;

        // Fault drops to standby and locks out restart
        if (fault) begin
            next_q.rw[0][EN_MODE_LSB +: 2] = MODE_STANDBY;
            next_q.locked   = 1'b1;
            next_q.seen_one = 1'b0;
            next_q.seen_two = 1'b0;
        end else if (q.locked && next_q.seen_one && next_q.seen_two) begin
            // Both flag registers read since the fault
            next_q.locked = 1'b0;
        end

        // Monitor selection follows the register only in standby
        if (next_q.rw[0][EN_MODE_LSB +: 2] == MODE_STANDBY) begin
            next_q.vmon_sel = next_q.rw[1][VMON_SEL_LSB +: 2];
        end

        // Registered controls to the power stage
        next_q.op_mode     = next_q.rw[0][EN_MODE_LSB +: 2];
        next_q.strobe_edge = next_q.rw[0][EN_STROBE_TYPE]
                             && (next_q.op_mode != MODE_INFRARED);
        next_q.vmon_level  = next_q.rw[1][VMON_LEVEL_LSB +: 3];
        next_q.led_one_code = next_q.rw[2][LED_CODE_LSB +: 7];
        next_q.busy        = (next_q.st != ST_IDLE);
    end

    // State register with power-on values
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            q <= '{st: ST_IDLE, rw: RW_RESET,
                   flags_one: FLAGS_RESET, flags_two: FLAGS_RESET,
                   prev_meta: PREV_FLASH_RESET, prev_sync: PREV_FLASH_RESET,
                   vmon_sel: RW_RESET[1][VMON_SEL_LSB +: 2],
                   op_mode: RW_RESET[0][EN_MODE_LSB +: 2],
                   strobe_edge: RW_RESET[0][EN_STROBE_TYPE],
                   vmon_level: RW_RESET[1][VMON_LEVEL_LSB +: 3],
                   led_one_code: RW_RESET[2][LED_CODE_LSB +: 7],
                   default: '0};
        end else begin
            q <= next_q;
        end
    end

    // Outputs straight from the state register, except SDA_OUT tied low
    assign SDA_OUT            = 1'b0;
    assign SDA_OE             = q.sda_oe;
    assign OP_MODE            = q.op_mode;
    assign STROBE_EDGE        = q.strobe_edge;
    assign VMON_LEVEL         = q.vmon_level;
    assign VMON_SELECT        = q.vmon_sel;
    assign LED_ONE_FLASH_CODE = q.led_one_code;
    assign RESTART_LOCKED     = q.locked;
    assign BUS_BUSY           = q.busy;

    // Checks on the transfer engine and bank
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!NRST);

    // Own address completed on a clock fall
    sequence own_addr_done;
        fall_ev && !start_ev && !stop_ev && q.st == ST_ADDR
        && q.bitcnt == BYTE_BITS && q.shift[7:1] == DEV_ADDR;
    endsequence

    // Data byte completed on a clock fall
    sequence data_done;
        fall_ev && !start_ev && !stop_ev && q.st == ST_WDATA
        && q.bitcnt == BYTE_BITS && is_rw(q.idx) && !q.locked
        && !(|q.fault_sync);
    endsequence

    chk_addr_ack_drive: assert property (own_addr_done |=> SDA_OE && q.st == ST_ADDR_ACK)
        else $error("own address not acknowledged");
    chk_foreign_release: assert property (
        fall_ev && !start_ev && !stop_ev && q.st == ST_ADDR && q.bitcnt == BYTE_BITS
        && q.shift[7:1] != DEV_ADDR |=> !SDA_OE && q.st == ST_IGNORE)
        else $error("foreign address acknowledged");
    chk_no_read_ack: assert property (q.st == ST_RACK |-> !SDA_OE)
        else $error("line driven during master answer");
    chk_start_restart: assert property (start_ev |=> q.st == ST_ADDR && q.bitcnt == 4'h0
        && !SDA_OE)
        else $error("start did not restart address reception");
    chk_stop_free: assert property (stop_ev && !start_ev |=> !BUS_BUSY)
        else $error("bus still busy after stop");
    chk_write_store: assert property (data_done
        |=> q.rw[rw_slot($past(q.idx))] == $past(q.shift))
        else $error("data byte not stored");
    chk_sda_on_fall: assert property ($changed(SDA_OE) |-> $past(fall_ev)
        || $past(start_ev) || $past(stop_ev))
        else $error("data line changed while clock high");
    chk_fault_standby: assert property ((|q.fault_sync) |=> OP_MODE == MODE_STANDBY
        && RESTART_LOCKED ##1 OP_MODE == MODE_STANDBY)
        else $error("fault did not force standby");
    chk_vmon_frozen: assert property (OP_MODE != MODE_STANDBY && next_q.op_mode != MODE_STANDBY
        |=> $stable(VMON_SELECT))
        else $error("monitor mode changed while enabled");
    chk_edge_not_infrared: assert property (OP_MODE == MODE_INFRARED |-> !STROBE_EDGE)
        else $error("edge strobe active in infrared mode");

endmodule

// ===== testbench/host_bfm.sv
// Purpose: Bus master model for the two-wire port
// Assumes: Pull-up on data, bus phases of 5 or 10 system clocks
// Notes:   Serial clock stands high outside frames
`timescale 1ns/1ps
module host_bfm (
    // Clock and device pull-down
    input  wire logic clk,
    input  wire logic oe,
    // Wire levels
    output logic      scl,
    output logic      sda
);
    logic low; // Master pulls data low
    initial begin
        scl = 1'b1;
        low = 1'b0;
    end
    // Pull-up unless a party pulls low
    assign sda = !(low || oe);
    task automatic w(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Start, also repeated start
    task automatic st();
        low = 1'b0;
        w(10);
        scl = 1'b1;
        w(10);
        low = 1'b1;
        w(10);
        scl = 1'b0;
        w(5);
    endtask
    // Stop frees the bus
    task automatic sp();
        low = 1'b1;
        w(5);
        scl = 1'b1;
        w(10);
        low = 1'b0;
        w(10);
    endtask
    // Data moves only while clock low
    task automatic bt(input logic b, output logic s);
        low = !b;
        w(5);
        scl = 1'b1;
        w(5);
        s = sda;
        w(5);
        scl = 1'b0;
        w(5);
    endtask
    // Byte MSB first, then the acknowledge slot
    task automatic by(input logic [7:0] d, input logic m, output logic [7:0] q, output logic k);
        for (int i = 7; i >= 0; i--) bt(d[i], q[i]);
        bt(m, k);
    endtask
endmodule

// ===== testbench/flash_register_bank_tb.sv
// Purpose: Self-checking bench for the flash register bank
// Assumes: Host model drives the bus, faults driven here
// Notes:   Read bytes are noted in a queue and compared by a watcher
`timescale 1ns/1ps
module flash_register_bank_tb;
    import flash_bank_pkg::*;
    logic clk_sys, nrst, scl, sda, oe, se, lk, bb, k;
    logic [7:0] f1, f2, pv, q, got, fv;
    logic [1:0] om, isel;
    logic [2:0] il;
    logic [6:0] lc;
    logic [7:0] note[$]; // Expected read bytes
    int bad_count, comparisons, seed = 32'h691E8A65;
    event ev;
    flash_register_bank i_flash_register_bank (.CLK_SYS(clk_sys), .NRST(nrst), .SCL(scl),
        .SDA_IN(sda), .SDA_OUT(), .SDA_OE(oe), .FAULT_ONE_EVENT(f1), .FAULT_TWO_EVENT(f2),
        .PREV_FLASH_LEVEL(pv), .OP_MODE(om), .STROBE_EDGE(se), .VMON_LEVEL(il),
        .VMON_SELECT(isel), .LED_ONE_FLASH_CODE(lc), .RESTART_LOCKED(lk), .BUS_BUSY(bb));
    host_bfm h (.clk(clk_sys), .oe(oe), .scl(scl), .sda(sda));
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    task automatic chk(input logic [7:0] s, input logic [7:0] e, input string n);
        comparisons++;
        if (s !== e) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Watcher takes the oldest note per read byte
    always @(ev) chk(got, note.pop_front(), "read");
    task automatic ad(input logic [7:0] b, input logic e);
        h.by(b, 1'b1, q, k);
        chk(8'(k), 8'(e), "ack");
    endtask
    task automatic wr(input logic [7:0] x, input logic [7:0] d);
        h.st();
        ad({DEV_ADDR, 1'b0}, 1'b0);
        ad(x, 1'b0);
        ad(d, 1'b0);
        h.sp();
        h.w(4);
    endtask
    task automatic rd(input logic [7:0] x, input logic [7:0] e);
        note.push_back(e);
        h.st();
        ad({DEV_ADDR, 1'b0}, 1'b0);
        ad(x, 1'b0);
        h.st();
        ad({DEV_ADDR, 1'b1}, 1'b0);
        h.by(8'hFF, 1'b1, got, k);
        ->ev;
        chk(8'(k), 8'h01, "rack");
        h.sp();
    endtask
    initial begin
        #500000;
        bad_count++;
        close_out();
    end
    initial begin
        nrst = 1'b0;
        f1 = 8'h00;
        f2 = 8'h00;
        pv = 8'($random(seed));
        repeat (12) @(negedge clk_sys);
        nrst = 1'b1;
        h.w(6);
        for (int i = 0; i < NUM_RW; i++) rd(8'(i + 1), RW_RESET[i]);
        rd(OFS_FLAGS_TWO, 8'h00);
        rd(OFS_PART_ID, PART_ID_DEFAULT);
        rd(OFS_PREV_FLASH, pv);
        chk(8'(isel), 8'(VMON_STOP_HOLD), "sel");
        $display("test reset done");
        for (int m = 0; m < 4; m++) begin
            wr(OFS_ENABLE, {2'b11, 2'b00, 2'(m), 2'b00});
            chk(8'(om), 8'(m), "mode");
            chk(8'(se), 8'(m != 1), "edge");
        end
        wr(OFS_VMON_CFG, 8'h2B);
        chk(8'(il), 8'h05, "level");
        chk(8'(isel), 8'(VMON_STOP_HOLD), "frozen");
        wr(OFS_ENABLE, 8'h80);
        chk(8'(isel), 8'(VMON_UP_DOWN), "sel");
        fv = 8'($random(seed));
        wr(OFS_FLASH_ONE, fv);
        chk(8'(lc), 8'(fv[6:0]), "led");
        $display("test fields done");
        wr(OFS_ENABLE, 8'h8C);
        fv = 8'($random(seed)) | 8'h01;
        f1 = fv;
        f2 = ~fv;
        h.w(10);
        f1 = 8'h00;
        f2 = 8'h00;
        h.w(5);
        chk(8'(om), 8'(MODE_STANDBY), "fmode");
        chk(8'(lk), 8'h01, "lock");
        wr(OFS_ENABLE, 8'h8C);
        chk(8'(om), 8'(MODE_STANDBY), "lmode");
        rd(OFS_FLAGS_ONE, fv);
        rd(OFS_FLAGS_TWO, ~fv);
        chk(8'(lk), 8'h00, "unlock");
        rd(OFS_FLAGS_ONE, 8'h00);
        wr(OFS_ENABLE, 8'h8C);
        chk(8'(om), 8'(MODE_FLASH), "rmode");
        $display("test fault done");
        h.st();
        chk(8'(bb), 8'h01, "busy");
        ad({7'h62, 1'b0}, 1'b1);
        ad(OFS_ENABLE, 1'b1);
        ad(8'h80, 1'b1);
        h.sp();
        h.w(6);
        chk(8'(bb), 8'h00, "free");
        chk(8'(om), 8'(MODE_FLASH), "kept");
        $display("test foreign done");
        h.w(20);
        close_out();
    end
endmodule
